// >>> rtl/ftc_pkg.sv
// package for the frame transfer cycler: register map, modes, record layout
`default_nettype none
package ftc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] FTC_ADDR_CTRL = 8'h00;
    localparam logic [7:0] FTC_ADDR_CMD = 8'h04;
    localparam logic [7:0] FTC_ADDR_STATUS = 8'h08;
    localparam logic [7:0] FTC_ADDR_MARK_EMPTY = 8'h0C;
    localparam logic [7:0] FTC_ADDR_BUF_FULL = 8'h10;
    localparam logic [7:0] FTC_ADDR_HELD = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FTC_CTRL_MODE_LSB = 0;
    localparam int FTC_CTRL_META_BIT = 2;
    localparam int FTC_CMD_START_BIT = 0;
    localparam int FTC_CMD_STOP_BIT = 1;
    localparam int FTC_CMD_ABORT_BIT = 2;
    localparam int FTC_ST_EOT_BIT = 0;
    localparam int FTC_ST_LOST_BIT = 1;
    localparam int FTC_ST_TRASH_BIT = 2;
    localparam int FTC_ST_RUN_BIT = 3;
    localparam int FTC_ST_BUSY_BIT = 4;
    localparam int FTC_ST_STOPPING_BIT = 5;
    localparam logic [1:0] FTC_CTRL_MODE_RESET = 2'h0;

    // ------------------------------------------------------------
    // record size: 64 bytes sent as 16 words
    // ------------------------------------------------------------
    localparam int FTC_REC_BYTES = 64;
    localparam int FTC_REC_WORDS = FTC_REC_BYTES / 4;
    localparam int FTC_RSV_BYTES = 25;

    // buffer cycling policy
    typedef enum logic [1:0] {
        FTC_WAIT_EMPTY,
        FTC_NEXT_EMPTY,
        FTC_ASYNC
    } ftc_mode_type;

    // line record, lowest byte last so that bits [32k+:32] are word k
    typedef struct packed {
        logic [FTC_RSV_BYTES*8-1:0] reserved;
        logic [7:0] bidir_pin_levels;
        logic [7:0] output_pin_levels;
        logic [7:0] input_pin_levels;
        logic [31:0] received_frame_number;
        logic [63:0] timestamp;
        logic [63:0] issued_line_trigger_total;
        logic [63:0] received_line_total;
        logic [63:0] encoder_position_count;
    } ftc_line_record_layout_type;

    // one transfer order toward a host buffer
    typedef struct packed {
        logic valid;
        logic [7:0] buffer;
    } ftc_dma_order_type;

endpackage

`default_nettype wire

// >>> rtl/ftc_cycler.sv
// frame transfer cycler with per-line record, behind an AHB-Lite slave
//
// Functional notes
// - held images forwarded in arrival order
// - no on-board room: drop, lost or trash
// - wait mode checks next buffer first
// - wait mode holds image while buffer full
// - start loads all buffers into queue
// - marked-empty buffers join queue in order
// - next-empty mode transfers while queue nonempty
// - async mode cycles ignoring buffer state
// - room but no buffer: keep image
// - trash only when buffers and memory exhausted
// - per-drop trash flag exposed
// - end of transfer after memory drains
// - optional 64-byte record after each line
// - record snapshot at line valid start
// - signed encoder position counter
// - 64-bit received line counter
// - 64-bit issued line trigger counter
// - 64-bit free-running timestamp
// - 32-bit received frame number
// - pin level bytes, one bit per pin
// - final 25 bytes reserved
`timescale 1ns/1ps
`default_nettype none

module ftc_cycler
    import ftc_pkg::*;
#(
    parameter int NBUF = 8,
    parameter int ONBOARD_FRAMES = 4
)(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // acquisition side
    input wire logic ACQ_FRAME,
    output logic ACQ_ACCEPT,
    output logic FRAME_LOST,
    output logic TRASH,
    output logic TRASH_FLAG,
    // host transfer engine
    output logic DMA_START,
    output logic [7:0] DMA_BUFFER,
    input wire logic DMA_DONE,
    output logic END_OF_TRANSFER,
    // line and pin status
    input wire logic LINE_VALID,
    input wire logic LINE_TRIGGER,
    input wire logic ENC_STEP,
    input wire logic ENC_REVERSE,
    input wire logic [7:0] INPUT_PINS,
    input wire logic [7:0] OUTPUT_PINS,
    input wire logic [7:0] BIDIR_PINS,
    // line record stream
    output logic META_VALID,
    input wire logic META_READY,
    output logic [31:0] META_DATA,
    output logic META_LAST
);

    localparam int IW = (NBUF > 1) ? $clog2(NBUF) : 1;
    localparam int CW = $clog2(ONBOARD_FRAMES + 1);
    localparam int QW = $clog2(NBUF + 1);
    localparam int WW = $clog2(FTC_REC_WORDS);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [1:0] ctrl_mode;
    logic meta_en;
    logic [NBUF-1:0] buf_full;
    logic running;
    logic stopping;
    logic busy;
    logic eot_flag;
    logic lost_flag;
    logic [CW-1:0] held;
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    wire addr_phase = HSEL && HREADY && HTRANS[1];
    wire wr_ctrl = ph_wr && (ph_addr == FTC_ADDR_CTRL);
    wire wr_cmd = ph_wr && (ph_addr == FTC_ADDR_CMD);
    wire wr_status = ph_wr && (ph_addr == FTC_ADDR_STATUS);
    wire wr_mark = ph_wr && (ph_addr == FTC_ADDR_MARK_EMPTY);
    wire cmd_start = wr_cmd && HWDATA[FTC_CMD_START_BIT];
    wire cmd_stop = wr_cmd && HWDATA[FTC_CMD_STOP_BIT];
    wire cmd_abort = wr_cmd && HWDATA[FTC_CMD_ABORT_BIT];
    wire [IW-1:0] mark_idx = HWDATA[IW-1:0];
    wire mark_ok = wr_mark && (HWDATA[7:0] < 8'(NBUF));
    wire ftc_mode_type mode = ftc_mode_type'(ctrl_mode);

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    // status word assembled from live state
    always_comb
    begin
        status_word = 32'h0;
        status_word[FTC_ST_EOT_BIT] = eot_flag;
        status_word[FTC_ST_LOST_BIT] = lost_flag;
        status_word[FTC_ST_TRASH_BIT] = TRASH_FLAG;
        status_word[FTC_ST_RUN_BIT] = running;
        status_word[FTC_ST_BUSY_BIT] = busy;
        status_word[FTC_ST_STOPPING_BIT] = stopping;
    end

    // read mux, unmapped reads give zero
    always_comb
    begin
        next_rdata = 32'h0;
        if (addr_phase && !HWRITE)
        begin
            unique case (HADDR)
                FTC_ADDR_CTRL: next_rdata = {29'h0, meta_en, ctrl_mode};
                FTC_ADDR_STATUS: next_rdata = status_word;
                FTC_ADDR_BUF_FULL: next_rdata = 32'(buf_full);
                FTC_ADDR_HELD: next_rdata = 32'(held);
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // address phase capture and read data
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ph_wr <= 1'b0;
            ph_addr <= 8'h00;
            HRDATA <= 32'h0;
        end
        else
        begin
            ph_wr <= addr_phase && HWRITE;
            ph_addr <= HADDR;
            HRDATA <= next_rdata;
        end
    end

    // control register
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ctrl_mode <= FTC_CTRL_MODE_RESET;
            meta_en <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ctrl_mode <= HWDATA[FTC_CTRL_MODE_LSB +: 2];
            meta_en <= HWDATA[FTC_CTRL_META_BIT];
        end
    end

    // ------------------------------------------------------------
    // empty buffer queue and buffer selection
    // ------------------------------------------------------------
    logic [IW-1:0] queue [NBUF];
    logic [IW-1:0] q_head;
    logic [IW-1:0] q_tail;
    logic [QW-1:0] q_count;
    logic [IW-1:0] ring_ptr;
    logic [IW-1:0] cur_buf;

    wire [IW-1:0] target = (mode == FTC_NEXT_EMPTY) ? queue[q_head] : ring_ptr;
    wire host_ready = (mode == FTC_NEXT_EMPTY) ? (q_count != '0) :
                      (mode == FTC_WAIT_EMPTY) ? !buf_full[ring_ptr] : 1'b1;
    wire launch = running || stopping;
    wire go = launch && !busy && (held != '0) && host_ready && !cmd_abort;
    wire q_pop = go && (mode == FTC_NEXT_EMPTY);
    wire q_push = mark_ok && (mode == FTC_NEXT_EMPTY) && (q_count != QW'(NBUF));
    wire [IW-1:0] head_inc = (q_head == IW'(NBUF - 1)) ? '0 : q_head + 1'b1;
    wire [IW-1:0] tail_inc = (q_tail == IW'(NBUF - 1)) ? '0 : q_tail + 1'b1;
    wire [IW-1:0] ring_inc = (ring_ptr == IW'(NBUF - 1)) ? '0 : ring_ptr + 1'b1;

    // queue storage and pointers
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            q_head <= '0;
            q_tail <= '0;
            q_count <= '0;
            for (int i = 0; i < NBUF; i++)
                queue[i] <= '0;
        end
        else if (cmd_start)
        begin
            q_head <= '0;
            q_tail <= '0;
            q_count <= QW'(NBUF);
            for (int i = 0; i < NBUF; i++)
                queue[i] <= IW'(i);
        end
        else
        begin
            if (q_push)
            begin
                queue[q_tail] <= mark_idx;
                q_tail <= tail_inc;
            end
            if (q_pop)
                q_head <= head_inc;
            if (q_push && !q_pop)
                q_count <= q_count + 1'b1;
            else if (q_pop && !q_push)
                q_count <= q_count - 1'b1;
        end
    end

    // buffer full/empty state, done marks full, software marks empty
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            buf_full <= '0;
        else
        begin
            for (int i = 0; i < NBUF; i++)
            begin
                if (busy && DMA_DONE && (cur_buf == IW'(i)))
                    buf_full[i] <= 1'b1;
                else if (mark_ok && (mark_idx == IW'(i)))
                    buf_full[i] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    // admission of a new image
    wire room = (held != CW'(ONBOARD_FRAMES));
    wire take = ACQ_FRAME && room && running;
    wire drop = ACQ_FRAME && !room && running;
    wire trash_mode = (mode != FTC_ASYNC);
    wire drop_trash = drop && trash_mode && !host_ready;
    wire drained = busy && DMA_DONE;
    wire eot_set = stopping && !busy && (held == '0) && !cmd_abort;

    // held count, run state and transfer engine handshake
    always_ff @(posedge CLK)
    begin
        if (!RSTN || cmd_abort)
        begin
            held <= '0;
            running <= 1'b0;
            stopping <= 1'b0;
            busy <= 1'b0;
            ring_ptr <= '0;
            cur_buf <= '0;
            DMA_START <= 1'b0;
            DMA_BUFFER <= 8'h00;
        end
        else
        begin
            DMA_START <= go;
            if (take && !drained)
                held <= held + 1'b1;
            else if (drained && !take)
                held <= held - 1'b1;
            if (cmd_start)
            begin
                running <= 1'b1;
                stopping <= 1'b0;
                ring_ptr <= '0;
            end
            else if (cmd_stop && running)
            begin
                running <= 1'b0;
                stopping <= 1'b1;
            end
            // drained after stop ends the run
            else if (eot_set)
                stopping <= 1'b0;
            if (go)
            begin
                busy <= 1'b1;
                cur_buf <= target;
                DMA_BUFFER <= 8'(target);
                if (mode != FTC_NEXT_EMPTY)
                    ring_ptr <= ring_inc;
            end
            else if (drained)
                busy <= 1'b0;
        end
    end

    // event pulses and sticky flags, a set beats a clear
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ACQ_ACCEPT <= 1'b0;
            FRAME_LOST <= 1'b0;
            TRASH <= 1'b0;
            END_OF_TRANSFER <= 1'b0;
            TRASH_FLAG <= 1'b0;
            lost_flag <= 1'b0;
            eot_flag <= 1'b0;
        end
        else
        begin
            ACQ_ACCEPT <= take;
            FRAME_LOST <= drop && !drop_trash;
            TRASH <= drop_trash;
            END_OF_TRANSFER <= eot_set;
            // trash flag of the latest drop
            if (drop)
                TRASH_FLAG <= drop_trash;
            else if (wr_status && HWDATA[FTC_ST_TRASH_BIT])
                TRASH_FLAG <= 1'b0;
            if (drop && !drop_trash)
                lost_flag <= 1'b1;
            else if (wr_status && HWDATA[FTC_ST_LOST_BIT])
                lost_flag <= 1'b0;
            if (eot_set)
                eot_flag <= 1'b1;
            else if (wr_status && HWDATA[FTC_ST_EOT_BIT])
                eot_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = 26;
    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;
    logic step_prev;
    logic line_prev;

    // two stages for both encoder inputs and all 24 pin levels
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            pin_meta <= '0;
            pin_sync <= '0;
        end
        else
        begin
            pin_meta <= {ENC_STEP, ENC_REVERSE, INPUT_PINS, OUTPUT_PINS, BIDIR_PINS};
            pin_sync <= pin_meta;
        end
    end

    wire step_s = pin_sync[25];
    wire rev_s = pin_sync[24];
    wire step_rise = step_s && !step_prev;
    wire line_rise = LINE_VALID && !line_prev;
    wire line_fall = !LINE_VALID && line_prev;

    // ------------------------------------------------------------
    // line record counters and snapshot
    // ------------------------------------------------------------
    logic [63:0] enc_count;
    logic [63:0] line_total;
    logic [63:0] trig_total;
    logic [63:0] tstamp;
    logic [31:0] frame_num;
    ftc_line_record_layout_type snap;

    // live counters
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            step_prev <= 1'b0;
            line_prev <= 1'b0;
            enc_count <= 64'h0;
            line_total <= 64'h0;
            trig_total <= 64'h0;
            tstamp <= 64'h0;
            frame_num <= 32'h0;
        end
        else
        begin
            step_prev <= step_s;
            line_prev <= LINE_VALID;
            tstamp <= tstamp + 64'h1;
            if (step_rise)
                enc_count <= rev_s ? enc_count - 64'h1 : enc_count + 64'h1;
            if (line_rise)
                line_total <= line_total + 64'h1;
            if (LINE_TRIGGER)
                trig_total <= trig_total + 64'h1;
            if (ACQ_FRAME)
                frame_num <= frame_num + 32'h1;
        end
    end

    // one snapshot at line valid start
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            snap <= '0;
        else if (line_rise)
        begin
            // fields placed by the packed layout
            snap.encoder_position_count <= enc_count;
            snap.received_line_total <= line_total + 64'h1;
            snap.issued_line_trigger_total <= trig_total;
            snap.timestamp <= tstamp;
            snap.received_frame_number <= frame_num;
            snap.input_pin_levels <= pin_sync[23:16];
            snap.output_pin_levels <= pin_sync[15:8];
            snap.bidir_pin_levels <= pin_sync[7:0];
            snap.reserved <= '0;
        end
    end

    // ------------------------------------------------------------
    // record stream after each line
    // ------------------------------------------------------------
    logic [WW-1:0] word_idx;
    wire [FTC_REC_BYTES*8-1:0] rec_bits = snap;
    wire meta_take = META_VALID && META_READY;
    wire [WW-1:0] word_nxt = word_idx + 1'b1;

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            META_VALID <= 1'b0;
            META_DATA <= 32'h0;
            META_LAST <= 1'b0;
            word_idx <= '0;
        end
        else if (line_fall && meta_en && !META_VALID)
        begin
            META_VALID <= 1'b1;
            META_DATA <= rec_bits[31:0];
            META_LAST <= 1'b0;
            word_idx <= '0;
        end
        else if (meta_take)
        begin
            if (META_LAST)
            begin
                META_VALID <= 1'b0;
                META_LAST <= 1'b0;
            end
            else
            begin
                META_DATA <= rec_bits[32*word_nxt +: 32];
                META_LAST <= (word_nxt == WW'(FTC_REC_WORDS - 1));
                word_idx <= word_nxt;
            end
        end
    end

endmodule // ftc_cycler

`default_nettype wire

// >>> testbench/ftc_cycler_chk.sv
// port checker for the frame transfer cycler
`timescale 1ns/1ps
`default_nettype none

module ftc_cycler_chk
    import ftc_pkg::*;
#(
    parameter int NBUF = 8
)(
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // acquisition and transfer
    input wire logic ACQ_FRAME,
    input wire logic ACQ_ACCEPT,
    input wire logic FRAME_LOST,
    input wire logic TRASH,
    input wire logic TRASH_FLAG,
    input wire logic DMA_START,
    input wire logic [7:0] DMA_BUFFER,
    input wire logic END_OF_TRANSFER,
    // line record
    input wire logic LINE_VALID,
    input wire logic META_VALID,
    input wire logic META_READY,
    input wire logic [31:0] META_DATA,
    input wire logic META_LAST
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RSTN);

    // ----------------------------------------
    // record word counter
    // ----------------------------------------
    logic [4:0] word_count;

    // counts accepted words, cleared after the last one
    always_ff @(posedge CLK)
    begin
        if (!RSTN || (META_VALID && META_READY && META_LAST))
            word_count <= 5'h00;
        else if (META_VALID && META_READY)
            word_count <= word_count + 5'h01;
    end

    a_answer_has_cause: assert property ((ACQ_ACCEPT | FRAME_LOST | TRASH) |-> $past(ACQ_FRAME))
        else $error("answer without a frame");
    a_single_answer: assert property ($onehot0({ACQ_ACCEPT, FRAME_LOST, TRASH}))
        else $error("two answers at once");
    a_trash_flag_set: assert property (TRASH |-> ##[0:1] TRASH_FLAG)
        else $error("trash flag not set");
    a_start_pulse: assert property (DMA_START |=> !DMA_START)
        else $error("start longer than one cycle");
    a_buffer_range: assert property (DMA_START |-> DMA_BUFFER < NBUF)
        else $error("buffer index out of ring");
    a_eot_alone: assert property (END_OF_TRANSFER |-> !DMA_START ##1 !END_OF_TRANSFER)
        else $error("end of transfer with work left");
    a_word_stands: assert property (META_VALID && !META_READY |=> META_VALID && $stable(META_DATA))
        else $error("record word dropped");
    a_record_length: assert property (META_VALID && META_LAST |-> word_count == 5'h0F)
        else $error("record not 16 words");
    a_record_after_line: assert property ($rose(META_VALID) |-> $past(LINE_VALID, 2) && !$past(LINE_VALID))
        else $error("record not after line end");

    // main scenarios reached
    c_trash: cover property (TRASH);
    c_lost: cover property (FRAME_LOST);
    c_eot: cover property (END_OF_TRANSFER);
    c_last: cover property (META_LAST && META_READY);
endmodule // ftc_cycler_chk

bind ftc_cycler ftc_cycler_chk #(.NBUF(NBUF)) ftc_cycler_chk_inst (
    .CLK(CLK), .RSTN(RSTN), .ACQ_FRAME(ACQ_FRAME), .ACQ_ACCEPT(ACQ_ACCEPT),
    .FRAME_LOST(FRAME_LOST), .TRASH(TRASH), .TRASH_FLAG(TRASH_FLAG), .DMA_START(DMA_START),
    .DMA_BUFFER(DMA_BUFFER), .END_OF_TRANSFER(END_OF_TRANSFER), .LINE_VALID(LINE_VALID),
    .META_VALID(META_VALID), .META_READY(META_READY), .META_DATA(META_DATA),
    .META_LAST(META_LAST)
);

`default_nettype wire

// >>> testbench/ftc_host_model.sv
// host memory model: finishes each transfer after a short or long delay
`timescale 1ns/1ps
`default_nettype none

module ftc_host_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // transfer engine
    input wire logic dma_start,
    input wire logic slow,
    output logic dma_done
);
    logic [5:0] remain;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            remain <= 6'h00;
        else if (dma_start)
            remain <= slow ? 6'h28 : 6'h03;
        else if (remain != 6'h00)
            remain <= remain - 6'h01;
    end

    // done pulse as the count runs out
    always_ff @(posedge clk)
    begin
        dma_done <= rstn && (remain == 6'h01);
    end
endmodule // ftc_host_model

`default_nettype wire

// >>> testbench/tb_top.sv
// testbench for the frame transfer cycler
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import ftc_pkg::*;
;
    logic clk = 0, rstn = 0, hwrite = 0, acq_frame = 0, line_valid = 0, line_trigger = 0;
    logic enc_step = 0, enc_reverse = 0, meta_ready = 0, slow = 0;
    logic [7:0] haddr = 0, in_pins = 0, out_pins = 0, bidir_pins = 0, dma_buffer;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, meta_data, rd;
    logic hreadyout, hresp, acq_accept, frame_lost, trash, trash_flag, dma_start, dma_done;
    logic eot, meta_valid, meta_last;
    logic [15:0] last;
    logic [7:0] bq[$];
    ftc_line_record_layout_type rec;
    int fail_count = 0, checks_done = 0, n_acc = 0, n_lost = 0, n_trash = 0, n_eot = 0;
    int n_frames = 0, k = 0;

    always #10 clk = ~clk;

    ftc_cycler #(.NBUF(4), .ONBOARD_FRAMES(2)) ftc_cycler_inst (
        .CLK(clk), .RSTN(rstn), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRESP(hresp), .HRDATA(hrdata), .ACQ_FRAME(acq_frame), .ACQ_ACCEPT(acq_accept),
        .FRAME_LOST(frame_lost), .TRASH(trash), .TRASH_FLAG(trash_flag),
        .DMA_START(dma_start), .DMA_BUFFER(dma_buffer), .DMA_DONE(dma_done),
        .END_OF_TRANSFER(eot), .LINE_VALID(line_valid), .LINE_TRIGGER(line_trigger),
        .ENC_STEP(enc_step), .ENC_REVERSE(enc_reverse), .INPUT_PINS(in_pins),
        .OUTPUT_PINS(out_pins), .BIDIR_PINS(bidir_pins), .META_VALID(meta_valid),
        .META_READY(meta_ready), .META_DATA(meta_data), .META_LAST(meta_last)
    );

    ftc_host_model ftc_host_model_inst (
        .clk(clk), .rstn(rstn), .dma_start(dma_start), .slow(slow), .dma_done(dma_done)
    );

    // logs transfer targets and event pulses
    always @(posedge clk)
    begin
        if (dma_start === 1'b1)
            bq.push_back(dma_buffer);
        n_acc += (acq_accept === 1'b1);
        n_lost += (frame_lost === 1'b1);
        n_trash += (trash === 1'b1);
        n_eot += (eot === 1'b1);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_buf(input logic [7:0] exp);
        chk(bq.size() != 0 ? bq.pop_front() : 8'hXX, exp);
    endtask

    // one single ahb-lite transfer
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk({hresp, rd}, {1'b0, exp});
    endtask

    task automatic frame();
        @(posedge clk);
        acq_frame <= 1'b1;
        n_frames++;
        @(posedge clk);
        acq_frame <= 1'b0;
        cyc(8);
    endtask

    task automatic conclude();
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog against a hang
    initial
    begin
        cyc(20000);
        fail_count++;
        conclude();
    end

    // main sequence
    initial
    begin
        cyc(2);
        rstn <= 1'b1;
        rdc(FTC_ADDR_STATUS, 32'h0);
        rdc(8'h20, 32'h0);
        // wait-for-empty ring
        bus(1'b1, FTC_ADDR_CTRL, 32'h0);
        bus(1'b1, FTC_ADDR_CMD, 32'h1);
        repeat (7) frame();
        for (int i = 0; i < 4; i++) chk_buf(i);
        rdc(FTC_ADDR_HELD, 32'h2);
        rdc(FTC_ADDR_BUF_FULL, 32'hF);
        chk(n_trash, 1);
        rdc(FTC_ADDR_STATUS, 32'hC);
        bus(1'b1, FTC_ADDR_MARK_EMPTY, 32'h1);
        cyc(10);
        chk(bq.size(), 0);
        bus(1'b1, FTC_ADDR_MARK_EMPTY, 32'h0);
        cyc(16);
        chk_buf(0);
        chk_buf(1);
        // next-empty queue
        bus(1'b1, FTC_ADDR_CMD, 32'h4);
        bus(1'b1, FTC_ADDR_CTRL, 32'h1);
        bus(1'b1, FTC_ADDR_CMD, 32'h1);
        repeat (4) frame();
        for (int i = 0; i < 4; i++) chk_buf(i);
        bus(1'b1, FTC_ADDR_MARK_EMPTY, 32'h2);
        bus(1'b1, FTC_ADDR_MARK_EMPTY, 32'h0);
        repeat (5) frame();
        chk_buf(2);
        chk_buf(0);
        chk(n_trash, 2);
        rdc(FTC_ADDR_HELD, 32'h2);
        bus(1'b1, FTC_ADDR_MARK_EMPTY, 32'h3);
        cyc(10);
        chk_buf(3);
        // async ring, overflow, stop
        bus(1'b1, FTC_ADDR_CMD, 32'h4);
        bus(1'b1, FTC_ADDR_CTRL, 32'h2);
        slow <= 1'b1;
        bus(1'b1, FTC_ADDR_CMD, 32'h1);
        repeat (3) frame();
        chk(n_lost, 1);
        chk(n_trash, 2);
        chk(n_eot, 0);
        bus(1'b1, FTC_ADDR_CMD, 32'h2);
        for (int i = 0; i < 300 && n_eot == 0; i++) @(posedge clk);
        chk(n_eot, 1);
        chk_buf(0);
        chk_buf(1);
        rdc(FTC_ADDR_HELD, 32'h0);
        chk(n_acc, 16);
        rdc(FTC_ADDR_STATUS, 32'h3);
        bus(1'b1, FTC_ADDR_STATUS, 32'h7);
        rdc(FTC_ADDR_STATUS, 32'h0);
        // line record
        slow <= 1'b0;
        bus(1'b1, FTC_ADDR_CTRL, 32'h4);
        in_pins <= 8'hA5;
        out_pins <= 8'h3C;
        bidir_pins <= 8'h81;
        for (int i = 0; i < 4; i++)
        begin
            enc_reverse <= (i == 3);
            @(posedge clk);
            enc_step <= 1'b1;
            line_trigger <= 1'b1;
            @(posedge clk);
            line_trigger <= 1'b0;
            cyc(4);
            enc_step <= 1'b0;
            cyc(4);
        end
        line_valid <= 1'b1;
        cyc(4);
        in_pins <= 8'hFF;
        cyc(2);
        line_valid <= 1'b0;
        for (int i = 0; i < 100 && k < 16; i++)
        begin
            @(posedge clk);
            if (meta_valid === 1'b1 && meta_ready === 1'b1)
            begin
                rec[32*k +: 32] = meta_data;
                last[k] = meta_last;
                k++;
            end
            meta_ready <= ~meta_ready;
        end
        chk(last, 16'h8000);
        chk(rec.encoder_position_count, 64'h2);
        chk(rec.received_line_total, 64'h1);
        chk(rec.issued_line_trigger_total, 64'h4);
        chk(rec.timestamp != 64'h0, 1);
        chk(rec.received_frame_number, n_frames);
        chk({rec.input_pin_levels, rec.output_pin_levels, rec.bidir_pin_levels}, 24'hA53C81);
        chk(rec.reserved == '0, 1);
        conclude();
    end
endmodule // tb_top

`default_nettype wire
